// [violation_monitor_pkg.sv]
// Package for the passive bus violation monitor.
// Assumes a single interface clock and active-low resets.
package violation_monitor_pkg;

  // Protocol selection
  typedef enum logic [1:0] {
    PROTO_FULL4 = 2'h0,
    PROTO_FULL3 = 2'h1,
    PROTO_LITE = 2'h2
  } proto_t;

  // Vector widths with and without extended checks
  localparam int VEC_W_BASE = 97;
  localparam int VEC_W_EXT = 128;

  // Fixed bit positions of implemented checks
  localparam int BIT_AW_STABLE = 0;
  localparam int BIT_W_STABLE = 1;
  localparam int BIT_AR_STABLE = 2;
  localparam int BIT_R_STABLE = 3;
  localparam int BIT_B_STABLE = 4;
  localparam int BIT_AW_DROP = 5;
  localparam int BIT_W_DROP = 6;
  localparam int BIT_AR_DROP = 7;
  localparam int BIT_R_DROP = 8;
  localparam int BIT_B_DROP = 9;
  localparam int BIT_B_ORPHAN = 10;
  localparam int BIT_R_ORPHAN = 11;
  localparam int BIT_AWLEN_LITE = 12;
  localparam int BIT_ARLEN_LITE = 13;
  localparam int BIT_BURST_RSVD = 14;
  localparam int BIT_AWLEN_A3 = 15;
  localparam int BIT_ARLEN_A3 = 16;

  // Outstanding transaction counter width
  localparam int OUTS_W = 8;
  localparam logic [OUTS_W-1:0] OUTS_ZERO = 8'h00;
  localparam logic [OUTS_W-1:0] OUTS_ONE = 8'h01;
  localparam logic [1:0] BURST_RSVD = 2'h3;
  localparam logic [7:0] LEN_A3_MAX = 8'h0f;
  localparam logic [7:0] LEN_ZERO = 8'h00;

endpackage : violation_monitor_pkg

// [violation_monitor.sv]
// Passive monitor of one bus connection, with sticky violation vector.
// Assumes monitored signals share clk; it only observes, never drives.
// Functional notes
// (R1) Checks follow the full, older or lite protocol chosen by configuration.
// (R2) Monitor only observes traffic; it never takes part in handshakes.
// (R3) A detected violation sets its vector bit synchronously on clk.
// (R4) Several bits may be set together or in different cycles.
// (R5) Set bits stay until interface or core reset; traffic never clears.
// (R6) Summary flag is high exactly while any vector bit is high.
// (R7) Optional lite control slave returns the current vector on reads.
// (R8) Full and older data width is a power of two, 32 to 1024.
// (R9) Lite data width is 32 or 64 only.
// (R10) Address width is configurable up to 64 bits.
// (R11) Each channel user width is configurable up to 1024 bits.
// (R12) Identifier width is configurable up to 32 bits.
// (R13) Several outstanding reads and writes are tracked for response checks.
// (R14) Vector is 97 bits, or 128 with extended checks enabled.
// (R15) One interface clock times monitor and control slave.
// (R16) Interface reset clears monitor and slave; core reset also accepted.
// (R17) All monitored signals are sampled on the rising clock edge.
// (R18) Each check has a fixed vector position.
module violation_monitor #(
  parameter violation_monitor_pkg::proto_t PROTOCOL =
    violation_monitor_pkg::PROTO_FULL4,
  parameter bit extended_checks_option = 1'b0,
  parameter int DATA_WIDTH = 32,
  parameter int ADDR_WIDTH = 32,
  parameter int ID_WIDTH = 4,
  parameter int AWUSER_WIDTH = 1,
  parameter int WUSER_WIDTH = 1,
  parameter int ARUSER_WIDTH = 1,
  parameter int RUSER_WIDTH = 1,
  parameter int BUSER_WIDTH = 1,
  parameter bit HAS_CTRL = 1'b1,
  localparam int VW = extended_checks_option ?
    violation_monitor_pkg::VEC_W_EXT : violation_monitor_pkg::VEC_W_BASE
) (
  input wire logic clk, // (R15)
  input wire logic nrst,
  input wire logic core_nrst,
  input wire logic ce,
  input wire logic [ID_WIDTH-1:0] awid,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [7:0] awlen,
  input wire logic [2:0] awsize,
  input wire logic [1:0] awburst,
  input wire logic [AWUSER_WIDTH-1:0] awuser,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [DATA_WIDTH-1:0] wdata,
  input wire logic [DATA_WIDTH/8-1:0] wstrb,
  input wire logic wlast,
  input wire logic [WUSER_WIDTH-1:0] wuser,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [ID_WIDTH-1:0] arid,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [7:0] arlen,
  input wire logic [2:0] arsize,
  input wire logic [1:0] arburst,
  input wire logic [ARUSER_WIDTH-1:0] aruser,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [ID_WIDTH-1:0] rid,
  input wire logic [DATA_WIDTH-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rlast,
  input wire logic [RUSER_WIDTH-1:0] ruser,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [ID_WIDTH-1:0] bid,
  input wire logic [1:0] bresp,
  input wire logic [BUSER_WIDTH-1:0] buser,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic [DATA_WIDTH-1:0] s_rdata,
  output logic [1:0] s_rresp,
  input wire logic [7:0] s_araddr,
  output logic [VW-1:0] violation_vector,
  output logic violation_any_flag
);

  // Parameter legality, caught at elaboration
  if ((PROTOCOL == violation_monitor_pkg::PROTO_LITE) &&
      !(DATA_WIDTH == 32 || DATA_WIDTH == 64)) begin : g_lite_w // (R9)
    $error("lite data width must be 32 or 64");
  end
  if ((PROTOCOL != violation_monitor_pkg::PROTO_LITE) &&
      (DATA_WIDTH < 32 || DATA_WIDTH > 1024 ||
       (DATA_WIDTH & (DATA_WIDTH - 1)) != 0)) begin : g_full_w // (R8)
    $error("data width must be a power of two from 32 to 1024");
  end
  if (ADDR_WIDTH > 64 || ID_WIDTH > 32) begin : g_aw // (R10) (R12)
    $error("address or id width too large");
  end
  if (AWUSER_WIDTH > 1024 || WUSER_WIDTH > 1024 || ARUSER_WIDTH > 1024 ||
      RUSER_WIDTH > 1024 || BUSER_WIDTH > 1024) begin : g_uw // (R11)
    $error("user width above 1024");
  end

  // Reset synchroniser; either reset clears, as the AND of both
  logic rst_m_q, rst_s_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end
  logic core_m_q, core_s_q;
  always_ff @(posedge clk or negedge core_nrst) begin
    if (!core_nrst) begin
      core_m_q <= 1'b0;
      core_s_q <= 1'b0;
    end else begin
      core_m_q <= 1'b1;
      core_s_q <= core_m_q;
    end
  end
  // Release is synchronous, so no register leaves reset a cycle early
  logic rst_n;
  assign rst_n = rst_s_q & core_s_q; // (R16)

  // Sampled copy of previous cycle handshake state, for stability checks
  localparam int AW_P = ID_WIDTH + ADDR_WIDTH + 13 + AWUSER_WIDTH;
  localparam int AR_P = ID_WIDTH + ADDR_WIDTH + 13 + ARUSER_WIDTH;
  localparam int W_P = DATA_WIDTH + DATA_WIDTH / 8 + 1 + WUSER_WIDTH;
  localparam int R_P = ID_WIDTH + DATA_WIDTH + 3 + RUSER_WIDTH;
  localparam int B_P = ID_WIDTH + 2 + BUSER_WIDTH;
  logic [AW_P-1:0] aw_pl;
  logic [AR_P-1:0] ar_pl;
  logic [W_P-1:0] w_pl;
  logic [R_P-1:0] r_pl;
  logic [B_P-1:0] b_pl;
  assign aw_pl = {awid, awaddr, awlen, awsize, awburst, awuser}; // (R2)
  assign ar_pl = {arid, araddr, arlen, arsize, arburst, aruser};
  assign w_pl = {wdata, wstrb, wlast, wuser};
  assign r_pl = {rid, rdata, rresp, rlast, ruser};
  assign b_pl = {bid, bresp, buser};

  // Stall flags remember valid without ready, so the next edge can judge
  logic [4:0] stall_q, stall_d; // Valid high, ready low last cycle
  logic [AW_P-1:0] aw_q, aw_d;
  logic [AR_P-1:0] ar_q, ar_d;
  logic [W_P-1:0] w_q, w_d;
  logic [R_P-1:0] r_q, r_d;
  logic [B_P-1:0] b_q, b_d;
  logic [violation_monitor_pkg::OUTS_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [VW-1:0] vec_q, vec_d;
  logic [VW-1:0] hit;

  // Check evaluation from inputs sampled at this edge
  always_comb begin
    hit = '0;
    hit[violation_monitor_pkg::BIT_AW_STABLE] = stall_q[0] && aw_pl != aw_q;
    hit[violation_monitor_pkg::BIT_W_STABLE] = stall_q[1] && w_pl != w_q;
    hit[violation_monitor_pkg::BIT_AR_STABLE] = stall_q[2] && ar_pl != ar_q;
    hit[violation_monitor_pkg::BIT_R_STABLE] = stall_q[3] && r_pl != r_q;
    hit[violation_monitor_pkg::BIT_B_STABLE] = stall_q[4] && b_pl != b_q;
    hit[violation_monitor_pkg::BIT_AW_DROP] = stall_q[0] && !awvalid;
    hit[violation_monitor_pkg::BIT_W_DROP] = stall_q[1] && !wvalid;
    hit[violation_monitor_pkg::BIT_AR_DROP] = stall_q[2] && !arvalid;
    hit[violation_monitor_pkg::BIT_R_DROP] = stall_q[3] && !rvalid;
    hit[violation_monitor_pkg::BIT_B_DROP] = stall_q[4] && !bvalid;
    hit[violation_monitor_pkg::BIT_B_ORPHAN] = bvalid && wr_q == '0; // (R13)
    hit[violation_monitor_pkg::BIT_R_ORPHAN] = rvalid && rd_q == '0; // (R13)
    if (PROTOCOL == violation_monitor_pkg::PROTO_LITE) begin // (R1)
      hit[violation_monitor_pkg::BIT_AWLEN_LITE] =
        awvalid && awlen != violation_monitor_pkg::LEN_ZERO;
      hit[violation_monitor_pkg::BIT_ARLEN_LITE] =
        arvalid && arlen != violation_monitor_pkg::LEN_ZERO;
    end else begin
      hit[violation_monitor_pkg::BIT_BURST_RSVD] =
        (awvalid && awburst == violation_monitor_pkg::BURST_RSVD) ||
        (arvalid && arburst == violation_monitor_pkg::BURST_RSVD);
    end
    if (PROTOCOL == violation_monitor_pkg::PROTO_FULL3) begin // (R1)
      hit[violation_monitor_pkg::BIT_AWLEN_A3] =
        awvalid && awlen > violation_monitor_pkg::LEN_A3_MAX;
      hit[violation_monitor_pkg::BIT_ARLEN_A3] =
        arvalid && arlen > violation_monitor_pkg::LEN_A3_MAX;
    end
  end

  // Next state: outstanding counts, samples, sticky vector
  always_comb begin
    stall_d = {bvalid && !bready, rvalid && !rready, arvalid && !arready,
               wvalid && !wready, awvalid && !awready}; // (R17)
    aw_d = aw_pl;
    ar_d = ar_pl;
    w_d = w_pl;
    r_d = r_pl;
    b_d = b_pl;
    wr_d = wr_q;
    rd_d = rd_q;
    if (awvalid && awready) begin // (R13)
      wr_d = wr_d + violation_monitor_pkg::OUTS_ONE;
    end
    if (bvalid && bready && wr_d != violation_monitor_pkg::OUTS_ZERO) begin
      wr_d = wr_d - violation_monitor_pkg::OUTS_ONE;
    end
    if (arvalid && arready) begin
      rd_d = rd_d + violation_monitor_pkg::OUTS_ONE;
    end
    if (rvalid && rready && (rlast ||
        PROTOCOL == violation_monitor_pkg::PROTO_LITE) &&
        rd_d != violation_monitor_pkg::OUTS_ZERO) begin
      rd_d = rd_d - violation_monitor_pkg::OUTS_ONE;
    end
    vec_d = vec_q | hit; // (R3) (R4) (R5) (R18)
  end

  // Registers, frozen while ce is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stall_q <= '0;
      aw_q <= '0;
      ar_q <= '0;
      w_q <= '0;
      r_q <= '0;
      b_q <= '0;
      wr_q <= violation_monitor_pkg::OUTS_ZERO;
      rd_q <= violation_monitor_pkg::OUTS_ZERO;
      vec_q <= '0; // (R16)
    end else if (ce) begin
      stall_q <= stall_d;
      aw_q <= aw_d;
      ar_q <= ar_d;
      w_q <= w_d;
      r_q <= r_d;
      b_q <= b_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
      vec_q <= vec_d;
    end
  end

  // Outputs come straight from the registered vector, never from hit
  assign violation_vector = vec_q; // (R14)
  assign violation_any_flag = |vec_q; // (R6)

  // Read-only control slave: word index selects a vector slice
  // Indexes past the vector read as zero; there is no error response
  localparam int NW = (VW + DATA_WIDTH - 1) / DATA_WIDTH;
  logic [NW*DATA_WIDTH-1:0] vec_pad;
  assign vec_pad = (NW*DATA_WIDTH)'(vec_q); // Zero fill, even if none needed
  logic rv_q, rv_d;
  logic [DATA_WIDTH-1:0] rdat_q, rdat_d;
  always_comb begin
    rv_d = rv_q;
    rdat_d = rdat_q;
    if (rv_q && s_rready) begin
      rv_d = 1'b0;
    end
    if (HAS_CTRL && s_arvalid && !rv_q) begin // (R7)
      rv_d = 1'b1;
      rdat_d = '0;
      for (int i = 0; i < NW; i++) begin
        if (s_araddr[7:2] == 6'(i)) begin
          rdat_d = vec_pad[i*DATA_WIDTH +: DATA_WIDTH];
        end
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_q <= 1'b0;
      rdat_q <= '0;
    end else if (ce) begin
      rv_q <= rv_d;
      rdat_q <= rdat_d;
    end
  end
  assign s_arready = HAS_CTRL && !rv_q && ce;
  assign s_rvalid = rv_q;
  assign s_rdata = rdat_q;
  assign s_rresp = 2'h0;

  // Sticky bits never fall while out of reset
  sticky_hold_a: assert property (@(posedge clk) disable iff (!rst_n) // (R5)
    ($past(vec_q) & ~vec_q) == '0) else $error("vector bit cleared");
  flag_tracks_a: assert property (@(posedge clk) disable iff (!rst_n) // (R6)
    violation_any_flag == (vec_q != '0)) else $error("flag wrong");
  hit_sets_a: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
    ce && hit != '0 |=> (vec_q & $past(hit)) == $past(hit))
    else $error("violation not recorded");
  orphan_b_a: assert property (@(posedge clk) disable iff (!rst_n) // (R13)
    ce && bvalid && wr_q == '0 |=> vec_q[violation_monitor_pkg::BIT_B_ORPHAN])
    else $error("orphan response missed");
  drop_aw_a: assert property (@(posedge clk) disable iff (!rst_n) // (R17)
    ce && awvalid && !awready ##1 ce && !awvalid
    |=> vec_q[violation_monitor_pkg::BIT_AW_DROP])
    else $error("valid drop missed");
  ctrl_read_a: assert property (@(posedge clk) disable iff (!rst_n) // (R7)
    s_arvalid && s_arready |=> s_rvalid) else $error("no read answer");
endmodule : violation_monitor

// [bus_model.sv]
// Far-side model: master and slave cores trading traffic on one bus.
// Assumes the bench calls its tasks; lines change at the falling clk edge.
module bus_model (
  input wire logic clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] awid, arid, rid, bid, wstrb;
  logic [31:0] awaddr, araddr, wdata, rdata;
  logic [7:0] awlen, arlen;
  logic [2:0] awsize, arsize;
  logic [1:0] awburst, arburst, rresp, bresp;
  logic awuser, wuser, aruser, ruser, buser, wlast, rlast;
  logic awvalid, awready, wvalid, wready, arvalid, arready;
  logic rvalid, rready, bvalid, bready;

  // Idle bus at time zero
  initial begin
    {awid, arid, rid, bid, wstrb, awaddr, araddr, wdata, rdata} = '0;
    {awlen, arlen, awsize, arsize, awburst, arburst, rresp, bresp} = '0;
    {awuser, wuser, aruser, ruser, buser, wlast, rlast} = '0;
    {awvalid, awready, wvalid, wready, arvalid, arready} = '0;
    {rvalid, rready, bvalid, bready} = '0;
  end

  // Write address; k=1 drops valid early, k=2 moves address while stalled
  task automatic aw_go(input int k, input logic [1:0] bt);
    @(negedge clk);
    awvalid = 1'h1;
    awburst = bt;
    @(negedge clk);
    if (k == 1) awvalid = 1'h0;
    else if (k == 2) awaddr = ~awaddr;
    awready = (k != 1);
    @(negedge clk);
    {awvalid, awready} = 2'h0;
    awaddr = ~awaddr; // Released payload never holds its old value
  endtask : aw_go

  // Read address; k=1 drops valid before ready
  task automatic ar_go(input int k);
    @(negedge clk);
    arvalid = 1'h1;
    arburst = 2'h1;
    @(negedge clk);
    arvalid = (k != 1);
    arready = (k != 1);
    @(negedge clk);
    {arvalid, arready} = 2'h0;
    araddr = ~araddr;
  endtask : ar_go

  // Single-beat data and responses, accepted at once
  task automatic w_go();
    @(negedge clk);
    {wvalid, wready, wlast} = 3'h7;
    @(negedge clk);
    {wvalid, wready, wlast} = 3'h0;
    wdata = ~wdata;
  endtask : w_go

  task automatic b_go();
    @(negedge clk);
    {bvalid, bready} = 2'h3;
    @(negedge clk);
    {bvalid, bready} = 2'h0;
  endtask : b_go

  task automatic r_go();
    @(negedge clk);
    {rvalid, rready, rlast} = 3'h7;
    @(negedge clk);
    {rvalid, rready, rlast} = 3'h0;
    rdata = ~rdata;
  endtask : r_go
endmodule : bus_model

// [axi_violation_monitor_bench.sv]
// Self-checking bench for the violation monitor.
// Assumes bus_model drives the watched bus; ce is held high until the last test drives it low.
module axi_violation_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int VW = violation_monitor_pkg::VEC_W_BASE;
  typedef struct {int k; int b;} row_t;
  logic clk, nrst, core_nrst, ce, s_arvalid, s_rready;
  logic s_arready, s_rvalid, violation_any_flag;
  logic [7:0] s_araddr;
  logic [31:0] s_rdata, wd;
  logic [1:0] s_rresp;
  logic [VW-1:0] violation_vector, ev;
  int err_total, checks;
  row_t rows[7];

  bus_model m (.clk(clk));
  violation_monitor dut (.clk(clk), .nrst(nrst), .core_nrst(core_nrst),
    .ce(ce), .awid(m.awid), .awaddr(m.awaddr), .awlen(m.awlen),
    .awsize(m.awsize), .awburst(m.awburst), .awuser(m.awuser),
    .awvalid(m.awvalid), .awready(m.awready), .wdata(m.wdata),
    .wstrb(m.wstrb), .wlast(m.wlast), .wuser(m.wuser), .wvalid(m.wvalid),
    .wready(m.wready), .arid(m.arid), .araddr(m.araddr), .arlen(m.arlen),
    .arsize(m.arsize), .arburst(m.arburst), .aruser(m.aruser),
    .arvalid(m.arvalid), .arready(m.arready), .rid(m.rid), .rdata(m.rdata),
    .rresp(m.rresp), .rlast(m.rlast), .ruser(m.ruser), .rvalid(m.rvalid),
    .rready(m.rready), .bid(m.bid), .bresp(m.bresp), .buser(m.buser),
    .bvalid(m.bvalid), .bready(m.bready), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_araddr(s_araddr),
    .violation_vector(violation_vector),
    .violation_any_flag(violation_any_flag));

  // Free-running 20 MHz clock
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  // Comparisons, one per kind of result
  task automatic cmp_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_bit

  task automatic cmp_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : cmp_word

  task automatic cmp_vec(input logic [VW-1:0] e);
    checks++;
    if (violation_vector !== e) begin
      err_total++;
      $display("BAD violation_vector exp %h got %h", e, violation_vector);
    end
    cmp_bit("violation_any_flag", |e, violation_any_flag);
  endtask : cmp_vec

  // Short interface reset; traffic may start on the third edge after
  task automatic do_reset();
    @(negedge clk);
    nrst = 1'h0;
    @(negedge clk);
    cmp_vec('0);
    nrst = 1'h1;
    repeat (3) @(negedge clk);
  endtask : do_reset

  // Control read; request held until the edge that takes it
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    s_arvalid = 1'h1;
    s_araddr = a;
    s_rready = 1'h1;
    while (s_arready !== 1'h1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    cmp_bit("s_arready", 1'h1, s_arready);
    @(negedge clk);
    s_arvalid = 1'h0;
    s_araddr = ~a;
    cmp_bit("s_rvalid", 1'h1, s_rvalid);
    cmp_bit("s_arready", 1'h0, s_arready);
    cmp_word("s_rresp", 32'h0000_0000, {30'h0000_0000, s_rresp});
    d = s_rdata;
    @(negedge clk);
    s_rready = 1'h0;
  endtask : rd

  // Traffic kinds used by the table rows
  task automatic run(input int k);
    case (k)
      0: m.aw_go(0, 2'h3);
      1: m.aw_go(1, 2'h1);
      2: m.aw_go(2, 2'h1);
      3: m.b_go();
      4: m.r_go();
      5: m.ar_go(1);
      default: begin
        m.aw_go(0, 2'h1);
        m.w_go();
        m.b_go();
      end
    endcase
  endtask : run

  task automatic wrap_up();
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  // Watchdog, far beyond the 160 or so cycles the tests need
  initial begin
    #1_000_000;
    err_total++;
    wrap_up();
  end

  // Table rows first, then the awkward cases
  initial begin
    {nrst, core_nrst, s_arvalid, s_rready} = 4'h0;
    ce = 1'h1;
    s_araddr = 8'h00;
    err_total = 0;
    checks = 0;
    rows = '{'{0, violation_monitor_pkg::BIT_BURST_RSVD},
      '{1, violation_monitor_pkg::BIT_AW_DROP},
      '{2, violation_monitor_pkg::BIT_AW_STABLE},
      '{3, violation_monitor_pkg::BIT_B_ORPHAN},
      '{4, violation_monitor_pkg::BIT_R_ORPHAN},
      '{5, violation_monitor_pkg::BIT_AR_DROP}, '{6, -1}};
    repeat (16) @(negedge clk);
    {nrst, core_nrst} = 2'h3;
    foreach (rows[i]) begin
      do_reset();
      run(rows[i].k);
      ev = '0;
      if (rows[i].b >= 0) ev[rows[i].b] = 1'h1;
      repeat (2) @(negedge clk);
      cmp_vec(ev);
    end
    do_reset();
    fork
      m.aw_go(1, 2'h1);
      m.ar_go(1);
    join
    ev = '0;
    ev[violation_monitor_pkg::BIT_AW_DROP] = 1'h1;
    ev[violation_monitor_pkg::BIT_AR_DROP] = 1'h1;
    repeat (2) @(negedge clk);
    cmp_vec(ev);
    run(6);
    m.ar_go(0);
    m.r_go();
    repeat (2) @(negedge clk);
    cmp_vec(ev);
    rd(8'h00, wd);
    cmp_word("s_rdata", ev[31:0], wd);
    rd(8'h0c, wd);
    cmp_word("s_rdata", {31'h0000_0000, ev[96]}, wd);
    rd(8'h10, wd);
    cmp_word("s_rdata", 32'h0000_0000, wd);
    @(negedge clk);
    core_nrst = 1'h0;
    @(negedge clk);
    cmp_vec('0);
    core_nrst = 1'h1;
    repeat (3) @(negedge clk);
    repeat (2) m.aw_go(0, 2'h1);
    repeat (2) m.w_go();
    repeat (2) m.b_go();
    repeat (2) @(negedge clk);
    cmp_vec('0);
    m.b_go();
    ev = '0;
    ev[violation_monitor_pkg::BIT_B_ORPHAN] = 1'h1;
    repeat (2) @(negedge clk);
    cmp_vec(ev);
    // Clock enable low: an orphan response must leave no trace
    do_reset();
    ce = 1'h0;
    m.b_go();
    cmp_bit("s_arready", 1'h0, s_arready);
    repeat (2) @(negedge clk);
    cmp_vec('0);
    ce = 1'h1;
    wrap_up();
  end
endmodule : axi_violation_monitor_bench
